// ### hdl/ifsb_bank.sv
/*
 * Interrupt flag status bank: three flag words set by peripheral requests,
 * a sticky event register with mask, and one level interrupt output.
 * Assumes a master that strobes one cycle at a time and never waits.
 */
// Added by the designer: strobed register access and the address map.
// How it works
// - flags hardware set, software readable/writable, reset zero
// - flag reads one after request, else zero
// - unimplemented positions always read zero
// - word0: converter 13, serial1 tx 12, rx 11
// - word0: sync port1 event 10, fault 9
// - word0: timer3 8, timer2 7, timer1 3
// - word0: compare2 6, capture2 5, compare1 2, capture1 1
// - word0: external pin0 at bit 0
// - word1: serial2 tx 15, rx 14
// - word1: external pin2 13, pin1 4
// - word1: timer5 12, timer4 11
// - word1: compare4/3 10/9, capture8/7 7/6
// - word1: pin change 3, comparator 2
// - word1: two-wire master 1, slave 0
// - word2: parallel port 13, absent on some variants
// - word2: compare8..5 at bits 12..9
// - word2: capture6..3 at bits 8..5
// - word2: sync port2 event 1, fault 0
`default_nettype none

module ifsb_bank #(
    parameter bit HAS_PARALLEL_PORT = 1'b1
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // register port
    input  wire ifsb_pkg::ifsb_addr_t regAddr,
    input  wire ifsb_pkg::ifsb_word_t regWrData,
    input  wire logic                 regWrStb,
    input  wire logic                 regRdStb,
    output ifsb_pkg::ifsb_word_t      regRdData_ff,
    // word 0 requests
    input  wire logic                 adcDoneReq,
    input  wire logic                 serial1TransmitReq,
    input  wire logic                 serial1ReceiveReq,
    input  wire logic                 syncPort1EventReq,
    input  wire logic                 syncPort1FaultReq,
    input  wire logic                 timer3Req,
    input  wire logic                 timer2Req,
    input  wire logic                 compare2Req,
    input  wire logic                 capture2Req,
    input  wire logic                 timer1Req,
    input  wire logic                 compare1Req,
    input  wire logic                 capture1Req,
    input  wire logic                 extPin0Req,
    // word 1 requests
    input  wire logic                 serial2TransmitReq,
    input  wire logic                 serial2ReceiveReq,
    input  wire logic                 extPin2Req,
    input  wire logic                 timer5Req,
    input  wire logic                 timer4Req,
    input  wire logic                 compare4Req,
    input  wire logic                 compare3Req,
    input  wire logic                 capture8Req,
    input  wire logic                 capture7Req,
    input  wire logic                 extPin1Req,
    input  wire logic                 pinChangeReq,
    input  wire logic                 comparatorReq,
    input  wire logic                 twowire1MasterReq,
    input  wire logic                 twowire1SlaveReq,
    // word 2 requests
    input  wire logic                 parallelPortReq,
    input  wire logic                 compare8Req,
    input  wire logic                 compare7Req,
    input  wire logic                 compare6Req,
    input  wire logic                 compare5Req,
    input  wire logic                 capture6Req,
    input  wire logic                 capture5Req,
    input  wire logic                 capture4Req,
    input  wire logic                 capture3Req,
    input  wire logic                 syncPort2EventReq,
    input  wire logic                 syncPort2FaultReq,
    // flag state towards priority logic
    output ifsb_pkg::ifsb_word_t      flagsWord0,
    output ifsb_pkg::ifsb_word_t      flagsWord1,
    output ifsb_pkg::ifsb_word_t      flagsWord2,
    // interrupt
    output logic                      irq
);

    // variants without the parallel port lose bit 13 of word 2
    localparam ifsb_pkg::ifsb_word_t IMPL2 = HAS_PARALLEL_PORT ? ifsb_pkg::IMPL_WORD2
                                                               : ifsb_pkg::IMPL_WORD2_NOPP;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic addrHit(input ifsb_pkg::ifsb_addr_t addr,
                                     input ifsb_pkg::ifsb_addr_t offs);
        addrHit = (addr == offs);
    endfunction

    logic hitFlags0;
    logic hitFlags1;
    logic hitFlags2;
    logic hitEvtStat;
    logic hitEvtMask;
    logic hitAny;

    assign hitFlags0  = addrHit(regAddr, ifsb_pkg::ADDR_FLAGS0);
    assign hitFlags1  = addrHit(regAddr, ifsb_pkg::ADDR_FLAGS1);
    assign hitFlags2  = addrHit(regAddr, ifsb_pkg::ADDR_FLAGS2);
    assign hitEvtStat = addrHit(regAddr, ifsb_pkg::ADDR_EVT_STAT);
    assign hitEvtMask = addrHit(regAddr, ifsb_pkg::ADDR_EVT_MASK);
    assign hitAny     = hitFlags0 | hitFlags1 | hitFlags2 | hitEvtStat | hitEvtMask;

    // ************************************************************
    // request assembly
    // ************************************************************
    ifsb_pkg::ifsb_word_t setWord0;
    ifsb_pkg::ifsb_word_t setWord1;
    ifsb_pkg::ifsb_word_t setWord2;

    always_comb begin
        setWord0 = 16'h0000;
        setWord0[ifsb_pkg::POS_ADC_DONE]    = adcDoneReq;
        setWord0[ifsb_pkg::POS_SER1_TX]     = serial1TransmitReq;
        setWord0[ifsb_pkg::POS_SER1_RX]     = serial1ReceiveReq;
        setWord0[ifsb_pkg::POS_SYNC1_EVENT] = syncPort1EventReq;
        setWord0[ifsb_pkg::POS_SYNC1_FAULT] = syncPort1FaultReq;
        setWord0[ifsb_pkg::POS_TIMER3]      = timer3Req;
        setWord0[ifsb_pkg::POS_TIMER2]      = timer2Req;
        setWord0[ifsb_pkg::POS_TIMER1]      = timer1Req;
        setWord0[ifsb_pkg::POS_COMPARE2]    = compare2Req;
        setWord0[ifsb_pkg::POS_CAPTURE2]    = capture2Req;
        setWord0[ifsb_pkg::POS_COMPARE1]    = compare1Req;
        setWord0[ifsb_pkg::POS_CAPTURE1]    = capture1Req;
        setWord0[ifsb_pkg::POS_EXT_PIN0]    = extPin0Req;
    end

    always_comb begin
        setWord1 = 16'h0000;
        setWord1[ifsb_pkg::POS_SER2_TX]     = serial2TransmitReq;
        setWord1[ifsb_pkg::POS_SER2_RX]     = serial2ReceiveReq;
        setWord1[ifsb_pkg::POS_EXT_PIN2]    = extPin2Req;
        setWord1[ifsb_pkg::POS_EXT_PIN1]    = extPin1Req;
        setWord1[ifsb_pkg::POS_TIMER5]      = timer5Req;
        setWord1[ifsb_pkg::POS_TIMER4]      = timer4Req;
        setWord1[ifsb_pkg::POS_COMPARE4]    = compare4Req;
        setWord1[ifsb_pkg::POS_COMPARE3]    = compare3Req;
        setWord1[ifsb_pkg::POS_CAPTURE8]    = capture8Req;
        setWord1[ifsb_pkg::POS_CAPTURE7]    = capture7Req;
        setWord1[ifsb_pkg::POS_PIN_CHANGE]  = pinChangeReq;
        setWord1[ifsb_pkg::POS_COMPARATOR]  = comparatorReq;
        setWord1[ifsb_pkg::POS_TW1_MASTER]  = twowire1MasterReq;
        setWord1[ifsb_pkg::POS_TW1_SLAVE]   = twowire1SlaveReq;
    end

    always_comb begin
        setWord2 = 16'h0000;
        setWord2[ifsb_pkg::POS_PARALLEL]    = parallelPortReq;
        setWord2[ifsb_pkg::POS_COMPARE8]    = compare8Req;
        setWord2[ifsb_pkg::POS_COMPARE7]    = compare7Req;
        setWord2[ifsb_pkg::POS_COMPARE6]    = compare6Req;
        setWord2[ifsb_pkg::POS_COMPARE5]    = compare5Req;
        setWord2[ifsb_pkg::POS_CAPTURE6]    = capture6Req;
        setWord2[ifsb_pkg::POS_CAPTURE5]    = capture5Req;
        setWord2[ifsb_pkg::POS_CAPTURE4]    = capture4Req;
        setWord2[ifsb_pkg::POS_CAPTURE3]    = capture3Req;
        setWord2[ifsb_pkg::POS_SYNC2_EVENT] = syncPort2EventReq;
        setWord2[ifsb_pkg::POS_SYNC2_FAULT] = syncPort2FaultReq;
    end

    // ************************************************************
    // flag words
    // ************************************************************
    ifsb_pkg::ifsb_evt_t newEvt;

    ifsb_flag_word #(
        .IMPL     (ifsb_pkg::IMPL_WORD0)
    ) u_word0 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .setReq   (setWord0),
        .wrEn     (regWrStb & hitFlags0),
        .wrData   (regWrData),
        .flags_ff (flagsWord0),
        .newEvent (newEvt[0])
    );

    ifsb_flag_word #(
        .IMPL     (ifsb_pkg::IMPL_WORD1)
    ) u_word1 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .setReq   (setWord1),
        .wrEn     (regWrStb & hitFlags1),
        .wrData   (regWrData),
        .flags_ff (flagsWord1),
        .newEvent (newEvt[1])
    );

    ifsb_flag_word #(
        .IMPL     (IMPL2)
    ) u_word2 (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .setReq   (setWord2),
        .wrEn     (regWrStb & hitFlags2),
        .wrData   (regWrData),
        .flags_ff (flagsWord2),
        .newEvent (newEvt[2])
    );

    // ************************************************************
    // event status and mask
    // ************************************************************
    // one event bit per word; set wins over a write-one clear
    ifsb_pkg::ifsb_evt_t evtStat_ff;
    ifsb_pkg::ifsb_evt_t evtMask_ff;
    ifsb_pkg::ifsb_evt_t evtClr;

    assign evtClr = (regWrStb & hitEvtStat) ? regWrData[ifsb_pkg::EVT_W-1:0] : ifsb_pkg::RESET_EVT;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evtStat_ff <= ifsb_pkg::RESET_EVT;
        end else begin
            evtStat_ff <= (evtStat_ff & ~evtClr) | newEvt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evtMask_ff <= ifsb_pkg::RESET_EVT;
        end else if (regWrStb & hitEvtMask) begin
            evtMask_ff <= regWrData[ifsb_pkg::EVT_W-1:0];
        end
    end

    assign irq = |(evtStat_ff & evtMask_ff);

    // ************************************************************
    // read path
    // ************************************************************
    // data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (rst || !regRdStb) begin
            regRdData_ff <= ifsb_pkg::RDATA_IDLE;
        end else if (hitFlags0) begin
            regRdData_ff <= flagsWord0;
        end else if (hitFlags1) begin
            regRdData_ff <= flagsWord1;
        end else if (hitFlags2) begin
            regRdData_ff <= flagsWord2;
        end else if (hitEvtStat) begin
            regRdData_ff <= {{(ifsb_pkg::DATA_W-ifsb_pkg::EVT_W){1'b0}}, evtStat_ff};
        end else if (hitEvtMask) begin
            regRdData_ff <= {{(ifsb_pkg::DATA_W-ifsb_pkg::EVT_W){1'b0}}, evtMask_ff};
        end else begin
            regRdData_ff <= ifsb_pkg::RDATA_IDLE;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_read_word0: assert property (@(posedge clk_sys) disable iff (rst)
        (regRdStb && hitFlags0) |=> (regRdData_ff == $past(flagsWord0)))
        else $error("word 0 read data wrong");

    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (regRdStb && !hitAny) |=> (regRdData_ff == 16'h0000))
        else $error("unmapped read not zero");

    a_idle_rdata: assert property (@(posedge clk_sys) disable iff (rst)
        !regRdStb |=> (regRdData_ff == 16'h0000))
        else $error("read data outside read slot");

    a_adc_position: assert property (@(posedge clk_sys) disable iff (rst)
        adcDoneReq |=> flagsWord0[13])
        else $error("converter flag not at bit 13");

    a_pin0_position: assert property (@(posedge clk_sys) disable iff (rst)
        extPin0Req |=> flagsWord0[0])
        else $error("external pin 0 flag not at bit 0");

    a_tw_slave_pos: assert property (@(posedge clk_sys) disable iff (rst)
        (setWord1 == 16'h0001 && flagsWord1 == 16'h0000 && !(regWrStb && hitFlags1))
        |=> (flagsWord1 == 16'h0001))
        else $error("two-wire slave flag not alone at bit 0");

    a_parallel_gone: assert property (@(posedge clk_sys)
        !HAS_PARALLEL_PORT |-> !flagsWord2[13])
        else $error("parallel port flag set on variant without it");

    a_evt_irq: assert property (@(posedge clk_sys) disable iff (rst)
        (newEvt[0] && evtMask_ff[0] && !(regWrStb && hitEvtMask)) |=> irq)
        else $error("unmasked event did not raise interrupt");

    a_sync1_evt_pos: assert property (@(posedge clk_sys) disable iff (rst)
        syncPort1EventReq |=> flagsWord0[10])
        else $error("sync port 1 event flag not at bit 10");

    a_timer1_pos: assert property (@(posedge clk_sys) disable iff (rst)
        timer1Req |=> flagsWord0[3])
        else $error("timer 1 flag not at bit 3");

    a_ser2_tx_pos: assert property (@(posedge clk_sys) disable iff (rst)
        serial2TransmitReq |=> flagsWord1[15])
        else $error("serial 2 transmit flag not at bit 15");

    a_pin2_pos: assert property (@(posedge clk_sys) disable iff (rst)
        extPin2Req |=> flagsWord1[13])
        else $error("external pin 2 flag not at bit 13");

    a_timer5_pos: assert property (@(posedge clk_sys) disable iff (rst)
        timer5Req |=> flagsWord1[12])
        else $error("timer 5 flag not at bit 12");

    a_capture8_pos: assert property (@(posedge clk_sys) disable iff (rst)
        capture8Req |=> flagsWord1[7])
        else $error("capture 8 flag not at bit 7");

    a_pin_change_pos: assert property (@(posedge clk_sys) disable iff (rst)
        pinChangeReq |=> flagsWord1[3])
        else $error("pin change flag not at bit 3");

    a_parallel_pos: assert property (@(posedge clk_sys) disable iff (rst)
        (HAS_PARALLEL_PORT && parallelPortReq) |=> flagsWord2[13])
        else $error("parallel port flag not at bit 13");

    a_compare8_pos: assert property (@(posedge clk_sys) disable iff (rst)
        compare8Req |=> flagsWord2[12])
        else $error("compare 8 flag not at bit 12");

    a_capture3_pos: assert property (@(posedge clk_sys) disable iff (rst)
        capture3Req |=> flagsWord2[5])
        else $error("capture 3 flag not at bit 5");

    a_sync2_fault_pos: assert property (@(posedge clk_sys) disable iff (rst)
        syncPort2FaultReq |=> flagsWord2[0])
        else $error("sync port 2 fault flag not at bit 0");

endmodule

`default_nettype wire

// ### hdl/ifsb_pkg.sv
/*
 * Constants for the interrupt flag status bank: register offsets, reset
 * values, implemented-bit masks and the bit position of every flag.
 * Assumes a 16-bit register port with byte addresses, one word per 4 bytes.
 */
`default_nettype none

package ifsb_pkg;

    // ************************************************************
    // widths and types
    // ************************************************************
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned EVT_W  = 3;

    typedef logic [DATA_W-1:0] ifsb_word_t;
    typedef logic [ADDR_W-1:0] ifsb_addr_t;
    typedef logic [EVT_W-1:0]  ifsb_evt_t;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam ifsb_addr_t ADDR_FLAGS0   = 8'h00;
    localparam ifsb_addr_t ADDR_FLAGS1   = 8'h04;
    localparam ifsb_addr_t ADDR_FLAGS2   = 8'h08;
    localparam ifsb_addr_t ADDR_EVT_STAT = 8'h0c;
    localparam ifsb_addr_t ADDR_EVT_MASK = 8'h10;

    // ************************************************************
    // reset values and implemented bits
    // ************************************************************
    localparam ifsb_word_t RESET_FLAGS     = 16'h0000;
    localparam ifsb_evt_t  RESET_EVT       = 3'h0;
    localparam ifsb_word_t RDATA_IDLE      = 16'h0000;
    localparam ifsb_word_t IMPL_WORD0      = 16'h3fef;
    localparam ifsb_word_t IMPL_WORD1      = 16'hfedf;
    localparam ifsb_word_t IMPL_WORD2      = 16'h3fe3;
    localparam ifsb_word_t IMPL_WORD2_NOPP = 16'h1fe3;

    // ************************************************************
    // word 0 positions
    // ************************************************************
    localparam int unsigned POS_ADC_DONE     = 13;
    localparam int unsigned POS_SER1_TX      = 12;
    localparam int unsigned POS_SER1_RX      = 11;
    localparam int unsigned POS_SYNC1_EVENT  = 10;
    localparam int unsigned POS_SYNC1_FAULT  = 9;
    localparam int unsigned POS_TIMER3       = 8;
    localparam int unsigned POS_TIMER2       = 7;
    localparam int unsigned POS_COMPARE2     = 6;
    localparam int unsigned POS_CAPTURE2     = 5;
    localparam int unsigned POS_TIMER1       = 3;
    localparam int unsigned POS_COMPARE1     = 2;
    localparam int unsigned POS_CAPTURE1     = 1;
    localparam int unsigned POS_EXT_PIN0     = 0;

    // ************************************************************
    // word 1 positions
    // ************************************************************
    localparam int unsigned POS_SER2_TX      = 15;
    localparam int unsigned POS_SER2_RX      = 14;
    localparam int unsigned POS_EXT_PIN2     = 13;
    localparam int unsigned POS_TIMER5       = 12;
    localparam int unsigned POS_TIMER4       = 11;
    localparam int unsigned POS_COMPARE4     = 10;
    localparam int unsigned POS_COMPARE3     = 9;
    localparam int unsigned POS_CAPTURE8     = 7;
    localparam int unsigned POS_CAPTURE7     = 6;
    localparam int unsigned POS_EXT_PIN1     = 4;
    localparam int unsigned POS_PIN_CHANGE   = 3;
    localparam int unsigned POS_COMPARATOR   = 2;
    localparam int unsigned POS_TW1_MASTER   = 1;
    localparam int unsigned POS_TW1_SLAVE    = 0;

    // ************************************************************
    // word 2 positions
    // ************************************************************
    localparam int unsigned POS_PARALLEL     = 13;
    localparam int unsigned POS_COMPARE8     = 12;
    localparam int unsigned POS_COMPARE7     = 11;
    localparam int unsigned POS_COMPARE6     = 10;
    localparam int unsigned POS_COMPARE5     = 9;
    localparam int unsigned POS_CAPTURE6     = 8;
    localparam int unsigned POS_CAPTURE5     = 7;
    localparam int unsigned POS_CAPTURE4     = 6;
    localparam int unsigned POS_CAPTURE3     = 5;
    localparam int unsigned POS_SYNC2_EVENT  = 1;
    localparam int unsigned POS_SYNC2_FAULT  = 0;

endpackage

`default_nettype wire

// ### hdl/ifsb_flag_word.sv
/*
 * One 16-bit flag word: hardware-set, software read/write, sticky.
 * Assumes set requests and writes are synchronous to clk_sys.
 */
`default_nettype none

module ifsb_flag_word #(
    parameter ifsb_pkg::ifsb_word_t IMPL = 16'hffff
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // hardware requests
    input  wire ifsb_pkg::ifsb_word_t setReq,
    // software write
    input  wire logic                 wrEn,
    input  wire ifsb_pkg::ifsb_word_t wrData,
    // state
    output ifsb_pkg::ifsb_word_t      flags_ff,
    output logic                      newEvent
);

    ifsb_pkg::ifsb_word_t setMasked;
    ifsb_pkg::ifsb_word_t wrMasked;
    ifsb_pkg::ifsb_word_t nxt_flags;

    assign setMasked = setReq & IMPL;
    assign wrMasked  = wrData & IMPL;

    // ************************************************************
    // flag update
    // ************************************************************
    // a request in the same cycle as a clearing write still lands
    always_comb begin
        nxt_flags = flags_ff;
        if (wrEn) begin
            nxt_flags = wrMasked;
        end
        nxt_flags = (nxt_flags | setMasked) & IMPL;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_ff <= ifsb_pkg::RESET_FLAGS;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign newEvent = |(setMasked & ~flags_ff);

    // ************************************************************
    // checks
    // ************************************************************
    a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (rst) (flags_ff & ~IMPL) == 16'h0000)
        else $error("unimplemented flag bit reads as one");

    a_hw_set_lands: assert property (@(posedge clk_sys) disable iff (rst)
        (setMasked != 16'h0000) |=> ((flags_ff & $past(setMasked)) == $past(setMasked)))
        else $error("hardware request did not set its flag");

    a_sticky_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !wrEn |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
        else $error("flag dropped without a software write");

    a_write_value: assert property (@(posedge clk_sys) disable iff (rst)
        (wrEn && setMasked == 16'h0000) |=> (flags_ff == $past(wrMasked)))
        else $error("software write not stored");

    a_reset_clear: assert property (@(posedge clk_sys) rst |=> (flags_ff == 16'h0000))
        else $error("flags not zero after reset");

endmodule

`default_nettype wire

// ### tb/ifsb_periph_model.sv
/*
 * Peripheral side model: raises interrupt requests as one-cycle pulses.
 * Assumes the bench strobes fireStb for one clk_sys cycle per burst.
 */
`default_nettype none

module ifsb_periph_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // command from the bench
    input  wire logic        fireStb,
    input  wire logic [47:0] firePat,
    // requests, word2:word1:word0
    output logic [47:0]      reqVec_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // request pulses
    // ************************************************************
    // shortest legal request: one cycle, so latching is really tested
    always_ff @(posedge clk_sys) begin
        reqVec_ff <= (rst || !fireStb) ? 48'h0 : firePat;
    end
endmodule

`default_nettype wire

// ### tb/ifsb_bank_tb_top.sv
/*
 * Self-checking bench for the flag status bank: random request bursts,
 * register reads and writes, unmapped access and the event interrupt.
 * Assumes the single-cycle register port and a 200 MHz clk_sys.
 */
`default_nettype none

module ifsb_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // signals
    // ************************************************************
    logic                 clk_sys = 1'b0;
    logic                 rst = 1'b1;
    ifsb_pkg::ifsb_addr_t regAddr = 8'h00;
    ifsb_pkg::ifsb_word_t regWrData = 16'h0000;
    logic                 regWrStb = 1'b0;
    logic                 regRdStb = 1'b0;
    ifsb_pkg::ifsb_word_t regRdData, fw0, fw1, fw2, d;
    logic                 irq;
    logic                 fireStb = 1'b0;
    logic [47:0]          firePat = 48'h0;
    logic [47:0]          rq, pat, implAll;
    int                   mismatches = 0;
    int                   compares = 0;
    ifsb_pkg::ifsb_addr_t adr[3] = '{ifsb_pkg::ADDR_FLAGS0, ifsb_pkg::ADDR_FLAGS1, ifsb_pkg::ADDR_FLAGS2};

    initial forever #2.5 clk_sys = ~clk_sys;

    ifsb_periph_model PEER (.clk_sys(clk_sys), .rst(rst), .fireStb(fireStb), .firePat(firePat), .reqVec_ff(rq));

    ifsb_bank DUT (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData_ff(regRdData), .adcDoneReq(rq[13]), .serial1TransmitReq(rq[12]),
        .serial1ReceiveReq(rq[11]), .syncPort1EventReq(rq[10]), .syncPort1FaultReq(rq[9]), .timer3Req(rq[8]),
        .timer2Req(rq[7]), .compare2Req(rq[6]), .capture2Req(rq[5]), .timer1Req(rq[3]), .compare1Req(rq[2]),
        .capture1Req(rq[1]), .extPin0Req(rq[0]), .serial2TransmitReq(rq[31]), .serial2ReceiveReq(rq[30]),
        .extPin2Req(rq[29]), .timer5Req(rq[28]), .timer4Req(rq[27]), .compare4Req(rq[26]), .compare3Req(rq[25]),
        .capture8Req(rq[23]), .capture7Req(rq[22]), .extPin1Req(rq[20]), .pinChangeReq(rq[19]),
        .comparatorReq(rq[18]), .twowire1MasterReq(rq[17]), .twowire1SlaveReq(rq[16]),
        .parallelPortReq(rq[45]), .compare8Req(rq[44]), .compare7Req(rq[43]), .compare6Req(rq[42]),
        .compare5Req(rq[41]), .capture6Req(rq[40]), .capture5Req(rq[39]), .capture4Req(rq[38]),
        .capture3Req(rq[37]), .syncPort2EventReq(rq[33]), .syncPort2FaultReq(rq[32]),
        .flagsWord0(fw0), .flagsWord1(fw1), .flagsWord2(fw2), .irq(irq));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input ifsb_pkg::ifsb_addr_t a, input ifsb_pkg::ifsb_word_t v);
        @(posedge clk_sys);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWrStb <= 1'b0;
        #1;
    endtask

    task automatic rd(input ifsb_pkg::ifsb_addr_t a, output ifsb_pkg::ifsb_word_t v);
        @(posedge clk_sys);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        #1 v = regRdData;
    endtask

    task automatic fire(input logic [47:0] p);
        @(posedge clk_sys);
        fireStb <= 1'b1;
        firePat <= p;
        @(posedge clk_sys);
        fireStb <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (4000) @(posedge clk_sys);
        mismatches++;
        give_verdict();
    end

    initial begin
        implAll = {ifsb_pkg::IMPL_WORD2, ifsb_pkg::IMPL_WORD1, ifsb_pkg::IMPL_WORD0};
        void'($urandom(32'h9e035b26));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        #1 chk("reset", 48'h0, {fw2, fw1, fw0});
        for (int i = 0; i < 24; i++) begin
            // corner bursts first: every source, none, two-wire slave alone
            pat = (i == 0) ? 48'hffffffffffff : (i == 1) ? 48'h0 :
                  (i == 2) ? 48'h000000010000 : 48'({$urandom(), $urandom()});
            for (int w = 0; w < 3; w++) wr(adr[w], 16'h0000);
            fire(pat);
            for (int w = 0; w < 3; w++) begin
                rd(adr[w], d);
                chk("readback", 48'(pat[w*16 +: 16] & implAll[w*16 +: 16]), 48'(d));
            end
            repeat (5) @(posedge clk_sys);
            #1 chk("sticky", pat & implAll, {fw2, fw1, fw0});
        end
        for (int w = 0; w < 3; w++) begin
            wr(adr[w], 16'hffff);
            rd(adr[w], d);
            chk("swset", 48'(implAll[w*16 +: 16]), 48'(d));
            wr(adr[w], 16'h0000);
            rd(adr[w], d);
            chk("swclr", 48'h0, 48'(d));
        end
        rd(8'h14, d);
        chk("unmapped", 48'h0, 48'(d));
        wr(ifsb_pkg::ADDR_EVT_STAT, 16'h0007);
        wr(ifsb_pkg::ADDR_EVT_MASK, 16'h0001);
        chk("irq idle", 48'h0, 48'(irq));
        fire(48'h000000000001);
        chk("irq set", 48'h1, 48'(irq));
        rd(ifsb_pkg::ADDR_EVT_STAT, d);
        chk("evt stat", 48'h1, 48'(d));
        wr(ifsb_pkg::ADDR_EVT_MASK, 16'h0000);
        chk("irq masked", 48'h0, 48'(irq));
        wr(ifsb_pkg::ADDR_EVT_MASK, 16'h0001);
        chk("irq unmasked", 48'h1, 48'(irq));
        wr(ifsb_pkg::ADDR_EVT_STAT, 16'h0001);
        chk("irq cleared", 48'h0, 48'(irq));
        give_verdict();
    end
endmodule

`default_nettype wire
